// ### design/asio_defines.svh
`ifndef ASIO_DEFINES_SVH
`define ASIO_DEFINES_SVH

`define ASIO_NUM_AXES 8
`define ASIO_POS_W 32
`define ASIO_POS_RST 32'h0000_0000

// encoder edge spacing at the fastest input rate
`define ASIO_CLK_KHZ 100000
`define ASIO_ENC_MAX_KHZ 5000
`define ASIO_ENC_EDGE_CYC ((`ASIO_CLK_KHZ) / ((`ASIO_ENC_MAX_KHZ) * 4))

`endif

// ### design/asio_pkg.sv
package asio_pkg;

    typedef enum logic [1:0] {
        ASIO_DRV_OFF   = 2'b00,
        ASIO_DRV_ON    = 2'b01,
        ASIO_DRV_FAULT = 2'b10
    } asio_drv_e;

    typedef logic [31:0] asio_pos_t;

endpackage

// ### design/asio_safety_io.sv
`include "asio_defines.svh"

module asio_safety_io #(
    parameter int NUM_AXES = `ASIO_NUM_AXES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // board-wide emergency stop pin
    input wire logic external_estop_in_i,
    // per-axis pins from encoder, switches and drive
    input wire logic [NUM_AXES-1:0] encoder_phase_a_i,
    input wire logic [NUM_AXES-1:0] encoder_phase_b_i,
    input wire logic [NUM_AXES-1:0] encoder_index_i,
    input wire logic [NUM_AXES-1:0] plus_end_limit_i,
    input wire logic [NUM_AXES-1:0] minus_end_limit_i,
    input wire logic [NUM_AXES-1:0] home_switch_in_i,
    input wire logic [NUM_AXES-1:0] in_position_in_i,
    input wire logic [NUM_AXES-1:0] servo_fault_in_i,
    // per-axis controls from the motion core
    input wire logic [NUM_AXES-1:0] motion_request_i,
    input wire logic [NUM_AXES-1:0] motion_dir_pos_i,
    input wire logic [NUM_AXES-1:0] pulse_mode_i,
    input wire logic [NUM_AXES-1:0] drive_enable_req_i,
    input wire logic [NUM_AXES-1:0] fault_clear_i,
    // per-axis pins to the drive
    output logic [NUM_AXES-1:0] drive_estop_out_o,
    output logic [NUM_AXES-1:0] drive_enable_out_o,
    // per-axis status to the motion core
    output logic [NUM_AXES-1:0] motion_permit_o,
    output logic [NUM_AXES-1:0] motion_abort_o,
    output logic [NUM_AXES-1:0] fault_latched_o,
    output logic [NUM_AXES-1:0] home_switch_o,
    output logic [NUM_AXES-1:0] index_event_o,
    output logic [NUM_AXES-1:0] in_position_event_o,
    output logic [NUM_AXES-1:0] servo_fault_event_o,
    output logic [NUM_AXES*`ASIO_POS_W-1:0] position_o
);

    // quadrature step from previous and current {a,b}: {valid, up}
    function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
        logic [3:0] idx;
        idx = {prev, cur};
        case (idx)
            4'h1, 4'h7, 4'he, 4'h8: quad_step = 2'h3;
            4'h2, 4'hb, 4'hd, 4'h4: quad_step = 2'h2;
            default: quad_step = 2'h0;
        endcase
    endfunction

    logic estop_s;
    logic [NUM_AXES-1:0] enc_a_s;
    logic [NUM_AXES-1:0] enc_b_s;
    logic [NUM_AXES-1:0] enc_z_s;
    logic [NUM_AXES-1:0] pel_s;
    logic [NUM_AXES-1:0] mel_s;
    logic [NUM_AXES-1:0] home_s;
    logic [NUM_AXES-1:0] inp_s;
    logic [NUM_AXES-1:0] alarm_s;
    logic [NUM_AXES-1:0] fault_now;

    // all pins are asynchronous to ref_clk_i
    asio_sync #(.W(1)) u_sync_estop (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(external_estop_in_i),
        .sync_o(estop_s)
    );
    asio_sync #(.W(NUM_AXES)) u_sync_enc_a (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(encoder_phase_a_i),
        .sync_o(enc_a_s)
    );
    asio_sync #(.W(NUM_AXES)) u_sync_enc_b (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(encoder_phase_b_i),
        .sync_o(enc_b_s)
    );
    asio_sync #(.W(NUM_AXES)) u_sync_enc_z (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(encoder_index_i),
        .sync_o(enc_z_s)
    );
    asio_sync #(.W(NUM_AXES)) u_sync_pel (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(plus_end_limit_i),
        .sync_o(pel_s)
    );
    asio_sync #(.W(NUM_AXES)) u_sync_mel (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(minus_end_limit_i),
        .sync_o(mel_s)
    );
    asio_sync #(.W(NUM_AXES)) u_sync_home (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(home_switch_in_i),
        .sync_o(home_s)
    );
    asio_sync #(.W(NUM_AXES)) u_sync_inp (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(in_position_in_i),
        .sync_o(inp_s)
    );
    asio_sync #(.W(NUM_AXES)) u_sync_alarm (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(servo_fault_in_i),
        .sync_o(alarm_s)
    );

    // a fault on any axis halts every axis
    logic fault_any;
    assign fault_any = |fault_now;

    genvar g;
    generate
        for (g = 0; g < NUM_AXES; g++) begin : g_axis
            asio_pkg::asio_drv_e drv_state;
            asio_pkg::asio_drv_e next_drv_state;
            logic [1:0] enc_prev;
            logic [1:0] next_enc_prev;
            logic z_prev;
            logic inp_prev;
            logic alarm_prev;
            logic next_z_prev;
            logic next_inp_prev;
            logic next_alarm_prev;
            asio_pkg::asio_pos_t pos;
            asio_pkg::asio_pos_t next_pos;
            logic [1:0] step;
            logic blocked;
            logic next_permit;
            logic next_abort;
            logic next_enable;
            logic next_estop;
            logic next_index_ev;
            logic next_inp_ev;
            logic next_fault_ev;
            logic next_home;

            assign fault_now[g] = (drv_state == asio_pkg::ASIO_DRV_FAULT);

            // encoder decode; 2FF delay is fine since edges are >= 5 cycles apart
            always_comb begin
                step = quad_step(enc_prev, {enc_a_s[g], enc_b_s[g]});
                next_enc_prev = {enc_a_s[g], enc_b_s[g]};
                next_pos = pos;
                if (step[1]) begin
                    next_pos = step[0] ? pos + 32'h1 : pos - 32'h1;
                end
                next_z_prev = enc_z_s[g];
                next_index_ev = enc_z_s[g] & ~z_prev;
            end

            // drive enable and fault latch
            always_comb begin
                next_drv_state = drv_state;
                case (drv_state)
                    asio_pkg::ASIO_DRV_OFF: begin
                        if (drive_enable_req_i[g] && !estop_s) begin
                            next_drv_state = asio_pkg::ASIO_DRV_ON;
                        end
                    end
                    asio_pkg::ASIO_DRV_ON: begin
                        if (alarm_s[g] && !alarm_prev && motion_permit_o[g]) begin
                            next_drv_state = asio_pkg::ASIO_DRV_FAULT;
                        end else if (!drive_enable_req_i[g]) begin
                            next_drv_state = asio_pkg::ASIO_DRV_OFF;
                        end
                    end
                    asio_pkg::ASIO_DRV_FAULT: begin
                        // clear refused while the alarm is still present
                        if (fault_clear_i[g] && !alarm_s[g]) begin
                            next_drv_state = asio_pkg::ASIO_DRV_OFF;
                        end
                    end
                    default: next_drv_state = asio_pkg::ASIO_DRV_OFF;
                endcase
                next_enable = (next_drv_state == asio_pkg::ASIO_DRV_ON);
            end

            // motion gating
            always_comb begin
                blocked = (motion_dir_pos_i[g] && pel_s[g])
                    || (!motion_dir_pos_i[g] && mel_s[g]);
                next_permit = motion_request_i[g] && !blocked && !estop_s
                    && !fault_any && (drv_state == asio_pkg::ASIO_DRV_ON);
                next_abort = motion_permit_o[g] & ~next_permit & motion_request_i[g];
                next_estop = estop_s;
                next_home = home_s[g];
                next_inp_prev = inp_s[g];
                next_inp_ev = inp_s[g] & ~inp_prev & pulse_mode_i[g];
                next_alarm_prev = alarm_s[g];
                next_fault_ev = alarm_s[g] & ~alarm_prev;
            end

            always_ff @(posedge ref_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    drv_state <= asio_pkg::ASIO_DRV_OFF;
                    enc_prev <= 2'h0;
                    z_prev <= 1'b0;
                    inp_prev <= 1'b0;
                    alarm_prev <= 1'b0;
                    pos <= `ASIO_POS_RST;
                    drive_estop_out_o[g] <= 1'b0;
                    drive_enable_out_o[g] <= 1'b0;
                    motion_permit_o[g] <= 1'b0;
                    motion_abort_o[g] <= 1'b0;
                    fault_latched_o[g] <= 1'b0;
                    home_switch_o[g] <= 1'b0;
                    index_event_o[g] <= 1'b0;
                    in_position_event_o[g] <= 1'b0;
                    servo_fault_event_o[g] <= 1'b0;
                    position_o[g*`ASIO_POS_W +: `ASIO_POS_W] <= `ASIO_POS_RST;
                end else begin
                    drv_state <= next_drv_state;
                    enc_prev <= next_enc_prev;
                    z_prev <= next_z_prev;
                    inp_prev <= next_inp_prev;
                    alarm_prev <= next_alarm_prev;
                    pos <= next_pos;
                    drive_estop_out_o[g] <= next_estop;
                    drive_enable_out_o[g] <= next_enable;
                    motion_permit_o[g] <= next_permit;
                    motion_abort_o[g] <= next_abort;
                    fault_latched_o[g] <= (next_drv_state == asio_pkg::ASIO_DRV_FAULT);
                    home_switch_o[g] <= next_home;
                    index_event_o[g] <= next_index_ev;
                    in_position_event_o[g] <= next_inp_ev;
                    servo_fault_event_o[g] <= next_fault_ev;
                    position_o[g*`ASIO_POS_W +: `ASIO_POS_W] <= next_pos;
                end
            end
        end
    endgenerate

endmodule

// ### design/asio_sync.sv
module asio_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end

endmodule

// ### tb/asio_drive_model.sv
module asio_drive_model #(
    parameter int N = 4
) (
    // clock
    input wire logic ref_clk_i,
    // from block and bench
    input wire logic [N-1:0] enable_i,
    input wire logic [N-1:0] estop_i,
    input wire logic [N-1:0] up_i,
    input wire logic [N-1:0] dn_i,
    input wire logic [N-1:0] inp_i,
    input wire logic [N-1:0] alm_i,
    // pins toward the block
    output logic [N-1:0] pha_o,
    output logic [N-1:0] phb_o,
    output logic [N-1:0] idx_o,
    output logic [N-1:0] inp_o,
    output logic [N-1:0] alm_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N-1:0][1:0] cnt = '0;
    always_ff @(posedge ref_clk_i) begin
        for (int g = 0; g < N; g++) begin
            // shaft turns only while enabled and not stopped
            if (enable_i[g] && !estop_i[g]) begin
                cnt[g] <= cnt[g] + {1'b0, up_i[g]} - {1'b0, dn_i[g]};
            end
        end
    end
    always_comb begin
        for (int g = 0; g < N; g++) begin
            pha_o[g] = cnt[g][1];
            phb_o[g] = cnt[g][1] ^ cnt[g][0];
        end
    end
    assign idx_o = pha_o & ~phb_o;
    // bench times the alarm; in-position follows the bench only while enabled
    assign inp_o = inp_i & enable_i;
    assign alm_o = alm_i;
endmodule

// ### tb/asio_safety_io_properties.sv
module asio_chk #(
    parameter int NUM_AXES = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // pins and core controls
    input wire logic external_estop_in_i,
    input wire logic [NUM_AXES-1:0] plus_end_limit_i,
    input wire logic [NUM_AXES-1:0] minus_end_limit_i,
    input wire logic [NUM_AXES-1:0] servo_fault_in_i,
    input wire logic [NUM_AXES-1:0] motion_request_i,
    input wire logic [NUM_AXES-1:0] motion_dir_pos_i,
    // outputs watched
    input wire logic [NUM_AXES-1:0] drive_estop_out_o,
    input wire logic [NUM_AXES-1:0] motion_permit_o,
    input wire logic [NUM_AXES-1:0] motion_abort_o,
    input wire logic [NUM_AXES-1:0] fault_latched_o,
    input wire logic [NUM_AXES-1:0] servo_fault_event_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // pin history reaches back into reset for four edges
    logic [2:0] live;
    logic [2:0] next_live;
    logic ok;
    always_comb begin
        next_live = (live == 3'h4) ? live : live + 3'h1;
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            live <= 3'h0;
        end else begin
            live <= next_live;
        end
    end
    assign ok = (live == 3'h4);
    a_estop_copy:
    assert property (ok |-> drive_estop_out_o == {NUM_AXES{$past(external_estop_in_i, 3)}})
        else $error("estop copy wrong");
    a_estop_halt:
    assert property (ok && $past(external_estop_in_i, 3) |-> motion_permit_o == '0)
        else $error("permit during estop");
    a_plus_block:
    assert property (ok |-> (motion_permit_o & $past(plus_end_limit_i, 3)
        & $past(motion_dir_pos_i)) == '0) else $error("plus limit ignored");
    a_minus_block:
    assert property (ok |-> (motion_permit_o & $past(minus_end_limit_i, 3)
        & ~$past(motion_dir_pos_i)) == '0) else $error("minus limit ignored");
    a_permit_req:
    assert property ((motion_permit_o & ~$past(motion_request_i)) == '0)
        else $error("permit without request");
    a_fault_halt:
    assert property (fault_latched_o != '0 && $past(fault_latched_o) != '0
        |-> motion_permit_o == '0) else $error("permit during fault");
    a_abort_single:
    assert property ((motion_abort_o & (motion_permit_o | $past(motion_abort_o))) == '0)
        else $error("abort pulse wrong");
    a_alarm_event:
    assert property (ok |-> servo_fault_event_o
        == ($past(servo_fault_in_i, 3) & ~$past(servo_fault_in_i, 4)))
        else $error("alarm event wrong");
    c_estop: cover property (drive_estop_out_o != '0);
    c_abort: cover property (motion_abort_o != '0);
    c_fault: cover property (fault_latched_o != '0);
endmodule

bind asio_safety_io asio_chk #(.NUM_AXES(NUM_AXES)) u_asio_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .external_estop_in_i(external_estop_in_i),
    .plus_end_limit_i(plus_end_limit_i), .minus_end_limit_i(minus_end_limit_i),
    .servo_fault_in_i(servo_fault_in_i), .motion_request_i(motion_request_i),
    .motion_dir_pos_i(motion_dir_pos_i), .drive_estop_out_o(drive_estop_out_o),
    .motion_permit_o(motion_permit_o), .motion_abort_o(motion_abort_o),
    .fault_latched_o(fault_latched_o), .servo_fault_event_o(servo_fault_event_o));

// ### tb/asio_safety_io_tb.sv
module asio_safety_io_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 4;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic estop = 1'b0;
    logic [N-1:0] pl = '0, mn = '0, home = '0, req = '0, dir = '0, pmode = '0, en_req = '0;
    logic [N-1:0] clr = '0, up = '0, dn = '0, inp = '0, servo_fault_in = '0;
    logic [N-1:0] ea, eb, ez, inp_pin, alm_pin, eso, en, prm, abt, flt, home_o, inp_ev, alm_ev;
    logic [N-1:0] abt_seen = '0, inp_seen = '0, alm_seen = '0;
    logic [N-1:0] idx_ev;
    logic [N-1:0] idx_seen = '0;
    logic [N*32-1:0] pos;
    int error_cnt = 0;
    int n_checks = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    // events last one cycle, so keep them sticky
    always @(posedge ref_clk_i) begin
        abt_seen <= abt_seen | abt;
        inp_seen <= inp_seen | inp_ev;
        alm_seen <= alm_seen | alm_ev;
        idx_seen <= idx_seen | idx_ev;
    end
    asio_safety_io #(.NUM_AXES(N)) u_asio_safety_io (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .external_estop_in_i(estop),
        .encoder_phase_a_i(ea), .encoder_phase_b_i(eb), .encoder_index_i(ez),
        .plus_end_limit_i(pl), .minus_end_limit_i(mn), .home_switch_in_i(home),
        .in_position_in_i(inp_pin), .servo_fault_in_i(alm_pin), .motion_request_i(req),
        .motion_dir_pos_i(dir), .pulse_mode_i(pmode), .drive_enable_req_i(en_req),
        .fault_clear_i(clr), .drive_estop_out_o(eso), .drive_enable_out_o(en),
        .motion_permit_o(prm), .motion_abort_o(abt), .fault_latched_o(flt),
        .home_switch_o(home_o), .index_event_o(idx_ev), .in_position_event_o(inp_ev),
        .servo_fault_event_o(alm_ev), .position_o(pos));
    asio_drive_model #(.N(N)) u_asio_drive_model (
        .ref_clk_i(ref_clk_i), .enable_i(en), .estop_i(eso), .up_i(up), .dn_i(dn),
        .inp_i(inp), .alm_i(servo_fault_in), .pha_o(ea), .phb_o(eb), .idx_o(ez), .inp_o(inp_pin),
        .alm_o(alm_pin));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic t_move;
        chk("enable", 32'(en), 32'h0);
        en_req = '1;
        cyc(6);
        chk("enable", 32'(en), 32'hf);
        // axis 3 counts up three steps, axis 0 down one
        for (int i = 0; i < 3; i++) begin
            up = 4'h8;
            dn = (i == 0) ? 4'h1 : 4'h0;
            cyc(1);
            up = '0;
            dn = '0;
            cyc(5);
        end
        chk("pos3", pos[96+:32], 32'h3);
        chk("pos0", pos[0+:32], 32'hffff_ffff);
        chk("pos1", pos[32+:32], 32'h0);
        // index pin rises once on axis 0 and once on axis 3
        chk("index event", 32'(idx_seen), 32'h9);
        $display("t_move done");
    endtask
    task automatic t_limit;
        req = 4'h1;
        dir = 4'h1;
        cyc(2);
        chk("permit", 32'(prm), 32'h1);
        pl = 4'h1;
        cyc(5);
        chk("permit", 32'(prm), 32'h0);
        chk("abort", 32'(abt_seen), 32'h1);
        dir = 4'h0;
        cyc(2);
        chk("permit", 32'(prm), 32'h1);
        mn = 4'h1;
        cyc(5);
        chk("permit", 32'(prm), 32'h0);
        pl = '0;
        dir = 4'h1;
        cyc(5);
        chk("permit", 32'(prm), 32'h1);
        mn = '0;
        $display("t_limit done");
    endtask
    task automatic t_estop;
        req = '1;
        dir = '1;
        cyc(2);
        estop = 1'b1;
        cyc(5);
        chk("estop out", 32'(eso), 32'hf);
        chk("permit", 32'(prm), 32'h0);
        estop = 1'b0;
        cyc(5);
        chk("permit", 32'(prm), 32'hf);
        $display("t_estop done");
    endtask
    task automatic t_events;
        home = 4'h2;
        inp = 4'h1;
        cyc(5);
        chk("home", 32'(home_o), 32'h2);
        chk("inp event", 32'(inp_seen), 32'h0);
        inp = '0;
        pmode = 4'h1;
        cyc(2);
        inp = 4'h1;
        cyc(5);
        chk("inp event", 32'(inp_seen), 32'h1);
        servo_fault_in = 4'h1;
        cyc(6);
        chk("fault", 32'(flt), 32'h1);
        chk("enable", 32'(en), 32'he);
        chk("permit", 32'(prm), 32'h0);
        chk("alarm event", 32'(alm_seen), 32'h1);
        servo_fault_in = '0;
        // clear is refused until the synced alarm has dropped
        cyc(3);
        clr = 4'h1;
        cyc(1);
        clr = '0;
        cyc(8);
        chk("permit", 32'(prm), 32'hf);
        $display("t_events done");
    endtask
    initial begin
        cyc(10);
        rst_i = 1'b0;
        cyc(2);
        t_move();
        t_limit();
        t_estop();
        t_events();
        end_of_test();
    end
    initial begin
        #20us;
        error_cnt++;
        end_of_test();
    end
endmodule
